/* pci_target_defines.vh */
// pci_target_defines.vh: shared constants of the target back-end port
// assumes inclusion by bare name from design files in the same folder
`ifndef PCI_TARGET_DEFINES_VH
`define PCI_TARGET_DEFINES_VH

// pci bus commands recognised by the core itself (configuration cycles)
`define PCI_CMD_CFG_READ   4'hA
`define PCI_CMD_CFG_WRITE  4'hB

// write buffer shape: data word plus its active-low byte enables
`define WBUF_DATA_W        32
`define WBUF_BE_W          4
`define WBUF_WIDTH         36
`define WBUF_DEPTH         16
`define WBUF_AW            4

// reset values
`define RST_WORD           32'h0000_0000
`define RST_BE_N           4'hF

`endif

/* word_fifo.v */
// word_fifo.v: first-word-fall-through fifo with valid/ready both sides
// assumes one clock and an active-low asynchronous reset already synced
`timescale 1ns/1ps

module word_fifo #(
  parameter WIDTH = 36,                 // word width
  parameter DEPTH = 16,                 // number of words
  parameter AW    = 4                   // address width, 2**AW == DEPTH
) (
  input  wire             clk_i,        // clock
  input  wire             rst_n_i,      // synced reset, active low
  input  wire             in_valid_i,   // producer offers a word
  output wire             in_ready_o,   // room for a word
  input  wire [WIDTH-1:0] in_data_i,    // word to store
  output wire             out_valid_o,  // head word present
  input  wire             out_ready_i,  // consumer takes the head
  output wire [WIDTH-1:0] out_data_o,   // head word
  output wire [AW:0]      level_o       // words held
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];      // storage array
  reg [AW-1:0]    wr_ptr_ff;            // next slot to write
  reg [AW-1:0]    rd_ptr_ff;            // head slot
  reg [AW:0]      count_ff;             // occupancy

  wire push = in_valid_i & in_ready_o;  // honest handshakes only
  wire pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (count_ff != DEPTH[AW:0]);
  assign out_valid_o = (count_ff != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr_ff];
  assign level_o     = count_ff;

  // storage has no reset; unread slots are never shown as valid
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  // pointers and occupancy; simultaneous push and pop keep the count
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule

/* pci_target_backend_port.v */
// pci_target_backend_port.v: pci target engine and its back-end port
// assumes pci inputs synchronous to clk_i and back-end logic on clk_i
`timescale 1ns/1ps
`include "pci_target_defines.vh"

module pci_target_backend_port (
  input  wire        clk_i,               // pci clock, 40 MHz
  input  wire        reset_n_i,           // async reset, active low
  input  wire        pci_frame_n_i,       // frame, active low
  input  wire        pci_irdy_n_i,        // initiator ready, active low
  input  wire        pci_idsel_i,         // config select
  input  wire [31:0] pci_ad_i,            // ad bus as seen
  input  wire [3:0]  pci_cbe_n_i,         // command / byte enables
  output wire [31:0] pci_ad_o,            // read data to ad bus
  output wire        pci_ad_oe_o,         // ad driven, high = drive
  output wire        pci_devsel_n_o,      // devsel, active low
  output wire        pci_trdy_n_o,        // target ready, active low
  output wire        pci_stop_n_o,        // stop, active low
  output wire        pci_tctl_oe_o,       // devsel/trdy/stop driven
  output wire [31:0] tgt_addr_wdata_o,    // address or write word
  output wire [3:0]  tgt_cmd_byte_en_o,   // command or byte enables
  output wire        addr_valid_o,        // first clock of access
  output wire        addr_step_o,         // one data word done
  input  wire        app_rd_cmd_hit_i,    // back-end read decode
  input  wire        app_wr_cmd_hit_i,    // back-end write decode
  input  wire        space_hit_i,         // address in device space
  output wire        app_write_o,         // user write in progress
  output wire        cfg_write_o,         // config write in progress
  output wire        app_read_o,          // user read in progress
  output wire        cfg_read_o,          // config read in progress
  input  wire        backend_ready_i,     // back-end ready
  input  wire        backend_stop_i,      // request disconnect
  input  wire        backend_abort_i,     // request target abort
  input  wire [31:0] backend_read_word_i, // user read data
  input  wire [31:0] cfg_read_word_i      // config read data
);

  localparam [2:0] S_IDLE  = 3'd0;        // waiting for a frame
  localparam [2:0] S_DEC   = 3'd1;        // address valid, decode
  localparam [2:0] S_RD    = 3'd2;        // read data phases
  localparam [2:0] S_WR    = 3'd3;        // write data phases
  localparam [2:0] S_STOP  = 3'd4;        // stop held until frame ends
  localparam [2:0] S_TURN  = 3'd5;        // drive controls high once
  localparam [2:0] S_DRAIN = 3'd6;        // empty write buffer
  localparam [2:0] S_WAIT  = 3'd7;        // not ours, let it pass

  // reset release through two flops
  reg        rst_meta_ff;                 // first stage
  reg        rst_sync_ff;                 // second stage, used below
  wire       rst_n = rst_sync_ff;         // synced reset

  reg [2:0]  state_ff;                    // current state
  reg [31:0] ad_ff;                       // read data driven on bus
  reg        ad_oe_ff;                    // ad driven
  reg        devsel_n_ff;                 // devsel
  reg        trdy_n_ff;                   // trdy
  reg        stop_n_ff;                   // stop
  reg        tctl_oe_ff;                  // control pins driven
  reg [31:0] addr_ff;                     // back-end address/data
  reg [3:0]  cbe_ff;                      // back-end command/enables
  reg        valid_ff;                    // address-valid
  reg        step_ff;                     // address-step
  reg        app_wr_ff;                   // user write flag
  reg        cfg_wr_ff;                   // config write flag
  reg        app_rd_ff;                   // user read flag
  reg        cfg_rd_ff;                   // config read flag
  reg        idsel_ff;                    // idsel caught with address
  reg        frame_prev_ff;               // frame one clock ago

  reg [2:0]  nxt_state;
  reg [31:0] nxt_ad;
  reg        nxt_ad_oe;
  reg        nxt_devsel_n;
  reg        nxt_trdy_n;
  reg        nxt_stop_n;
  reg        nxt_tctl_oe;
  reg [31:0] nxt_addr;
  reg [3:0]  nxt_cbe;
  reg        nxt_valid;
  reg        nxt_step;
  reg        nxt_app_wr;
  reg        nxt_cfg_wr;
  reg        nxt_app_rd;
  reg        nxt_cfg_rd;
  reg        nxt_idsel;
  reg        push;                        // write word into buffer

  wire [35:0] fifo_out;                   // head: {be_n, data}
  wire        fifo_out_valid;             // buffer holds a word
  wire        fifo_in_ready;              // buffer has room
  wire [4:0]  fifo_level;                 // words held

  // a data phase completes when both readies are low together
  wire xfer = ~trdy_n_ff & ~pci_irdy_n_i;
  // new frame only on a falling edge, so a missed frame is not re-seen
  wire frame_start = frame_prev_ff & ~pci_frame_n_i;
  wire term_req = backend_stop_i | backend_abort_i;
  // write buffer drains whenever the back-end is ready
  wire pop = fifo_out_valid & backend_ready_i;
  // room check counts the word landing this edge; pop is ignored so
  // that trdy never promises a slot that a stalled back-end keeps full
  wire [5:0] fill_next = {1'b0, fifo_level} + {5'd0, push};
  wire room = (fill_next < `WBUF_DEPTH);

  wire dec_cfg_rd = valid_ff & idsel_ff & (cbe_ff == `PCI_CMD_CFG_READ);
  wire dec_cfg_wr = valid_ff & idsel_ff & (cbe_ff == `PCI_CMD_CFG_WRITE);
  wire usr_hit = valid_ff & ~idsel_ff & space_hit_i;
  wire dec_usr_rd = usr_hit & app_rd_cmd_hit_i;
  wire dec_usr_wr = usr_hit & app_wr_cmd_hit_i & ~app_rd_cmd_hit_i;

  // reset synchroniser: the second flop alone feeds the design
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  word_fifo #(
    .WIDTH (`WBUF_WIDTH),
    .DEPTH (`WBUF_DEPTH),
    .AW    (`WBUF_AW)
  ) u_wbuf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({pci_cbe_n_i, pci_ad_i}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_out),
    .level_o     (fifo_level)
  );

  // next-state and output decisions of the target engine
  always @* begin
    nxt_state    = state_ff;
    nxt_ad       = ad_ff;
    nxt_ad_oe    = ad_oe_ff;
    nxt_devsel_n = devsel_n_ff;
    nxt_trdy_n   = trdy_n_ff;
    nxt_stop_n   = stop_n_ff;
    nxt_tctl_oe  = tctl_oe_ff;
    nxt_addr     = addr_ff;
    nxt_cbe      = cbe_ff;
    nxt_valid    = 1'b0;
    nxt_step     = 1'b0;
    nxt_app_wr   = app_wr_ff;
    nxt_cfg_wr   = cfg_wr_ff;
    nxt_app_rd   = app_rd_ff;
    nxt_cfg_rd   = cfg_rd_ff;
    nxt_idsel    = idsel_ff;
    push         = 1'b0;
    if (pop) begin
      nxt_addr = fifo_out[31:0];
      nxt_cbe  = fifo_out[35:32];
      nxt_step = 1'b1;
    end
    case (state_ff)
      S_IDLE: begin
        if (frame_start) begin
          nxt_addr  = pci_ad_i;
          nxt_cbe   = pci_cbe_n_i;
          nxt_valid = 1'b1;
          nxt_idsel = pci_idsel_i;
          nxt_state = S_DEC;
        end
      end
      S_DEC: begin
        // claim the cycle only when some decode hit
        if (dec_cfg_rd | dec_cfg_wr | dec_usr_rd | dec_usr_wr) begin
          nxt_devsel_n = 1'b0;
          nxt_tctl_oe  = 1'b1;
          nxt_app_wr   = dec_usr_wr;
          nxt_cfg_wr   = dec_cfg_wr;
          nxt_app_rd   = dec_usr_rd;
          nxt_cfg_rd   = dec_cfg_rd;
          if (dec_cfg_rd | dec_usr_rd) begin
            nxt_state = S_RD;
          end else begin
            nxt_trdy_n = 1'b0;
            nxt_state  = S_WR;
          end
        end else begin
          nxt_state = S_WAIT;
        end
      end
      S_RD: begin
        nxt_ad_oe = 1'b1;
        nxt_cbe   = pci_cbe_n_i;
        if (xfer) begin
          nxt_step   = 1'b1;
          nxt_trdy_n = 1'b1;
        end
        if (xfer & pci_frame_n_i) begin
          nxt_state = S_TURN;
        end else if (term_req) begin
          nxt_trdy_n   = 1'b1;
          nxt_stop_n   = 1'b0;
          nxt_devsel_n = backend_abort_i;
          nxt_state    = S_STOP;
        end else if (!xfer && trdy_n_ff && !step_ff && backend_ready_i) begin
          nxt_ad     = cfg_rd_ff ? cfg_read_word_i : backend_read_word_i;
          nxt_trdy_n = 1'b0;
        end
      end
      S_WR: begin
        push = xfer;
        if (xfer & pci_frame_n_i) begin
          nxt_state = S_TURN;
        end else if (term_req) begin
          nxt_trdy_n   = 1'b1;
          nxt_stop_n   = 1'b0;
          nxt_devsel_n = backend_abort_i;
          nxt_state    = S_STOP;
        end else begin
          nxt_trdy_n = ~room;
        end
      end
      S_STOP: begin
        // stop stays low until the initiator releases frame
        if (pci_frame_n_i) begin
          nxt_state = S_TURN;
        end
      end
      S_TURN: begin
        nxt_tctl_oe = 1'b0;
        nxt_app_rd  = 1'b0;
        nxt_cfg_rd  = 1'b0;
        nxt_state   = (app_wr_ff | cfg_wr_ff) ? S_DRAIN : S_IDLE;
      end
      S_DRAIN: begin
        // frames arriving here are not claimed: they master-abort
        // write flag stays up until the last step ends
        if (!fifo_out_valid) begin
          nxt_app_wr = 1'b0;
          nxt_cfg_wr = 1'b0;
          nxt_state  = S_IDLE;
        end
      end
      S_WAIT: begin
        if (pci_frame_n_i) begin
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    // on entry to turnaround drive the controls high for one clock
    if (nxt_state == S_TURN && state_ff != S_TURN) begin
      nxt_devsel_n = 1'b1;
      nxt_trdy_n   = 1'b1;
      nxt_stop_n   = 1'b1;
      nxt_ad_oe    = 1'b0;
    end
  end

  // state register; every output below leaves straight from here
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff      <= S_IDLE;
      ad_ff         <= `RST_WORD;
      ad_oe_ff      <= 1'b0;
      devsel_n_ff   <= 1'b1;
      trdy_n_ff     <= 1'b1;
      stop_n_ff     <= 1'b1;
      tctl_oe_ff    <= 1'b0;
      addr_ff       <= `RST_WORD;
      cbe_ff        <= `RST_BE_N;
      valid_ff      <= 1'b0;
      step_ff       <= 1'b0;
      app_wr_ff     <= 1'b0;
      cfg_wr_ff     <= 1'b0;
      app_rd_ff     <= 1'b0;
      cfg_rd_ff     <= 1'b0;
      idsel_ff      <= 1'b0;
      frame_prev_ff <= 1'b1;
    end else begin
      state_ff      <= nxt_state;
      ad_ff         <= nxt_ad;
      ad_oe_ff      <= nxt_ad_oe;
      devsel_n_ff   <= nxt_devsel_n;
      trdy_n_ff     <= nxt_trdy_n;
      stop_n_ff     <= nxt_stop_n;
      tctl_oe_ff    <= nxt_tctl_oe;
      addr_ff       <= nxt_addr;
      cbe_ff        <= nxt_cbe;
      valid_ff      <= nxt_valid;
      step_ff       <= nxt_step;
      app_wr_ff     <= nxt_app_wr;
      cfg_wr_ff     <= nxt_cfg_wr;
      app_rd_ff     <= nxt_app_rd;
      cfg_rd_ff     <= nxt_cfg_rd;
      idsel_ff      <= nxt_idsel;
      frame_prev_ff <= pci_frame_n_i;
    end
  end

  assign pci_ad_o          = ad_ff;
  assign pci_ad_oe_o       = ad_oe_ff;
  assign pci_devsel_n_o    = devsel_n_ff;
  assign pci_trdy_n_o      = trdy_n_ff;
  assign pci_stop_n_o      = stop_n_ff;
  assign pci_tctl_oe_o     = tctl_oe_ff;
  assign tgt_addr_wdata_o  = addr_ff;
  assign tgt_cmd_byte_en_o = cbe_ff;
  assign addr_valid_o      = valid_ff;
  assign addr_step_o       = step_ff;
  assign app_write_o       = app_wr_ff;
  assign cfg_write_o       = cfg_wr_ff;
  assign app_read_o        = app_rd_ff;
  assign cfg_read_o        = cfg_rd_ff;

endmodule

/* pci_target_backend_port_chk.sv */
// pci_target_backend_port_chk.sv: timing checks on the target port pins
// assumes one clock domain and binding onto the design top module
`timescale 1ns/1ps

module pci_target_backend_port_chk (
  input wire logic        clk_i,             // clock
  input wire logic        reset_n_i,         // reset, low
  input wire logic        pci_frame_n_i,     // frame
  input wire logic        pci_irdy_n_i,      // master ready
  input wire logic [31:0] pci_ad_i,          // ad bus
  input wire logic [3:0]  pci_cbe_n_i,       // command / enables
  input wire logic        pci_devsel_n_o,    // devsel
  input wire logic        pci_trdy_n_o,      // target ready
  input wire logic        pci_stop_n_o,      // stop
  input wire logic [31:0] tgt_addr_wdata_o,  // address / word
  input wire logic [3:0]  tgt_cmd_byte_en_o, // command / enables
  input wire logic        addr_valid_o,      // address strobe
  input wire logic        addr_step_o,       // step pulse
  input wire logic        app_rd_cmd_hit_i,  // read decode
  input wire logic        app_wr_cmd_hit_i,  // write decode
  input wire logic        space_hit_i,       // window hit
  input wire logic        app_write_o,       // user write
  input wire logic        app_read_o,        // user read
  input wire logic        cfg_write_o,       // config write
  input wire logic        cfg_read_o,        // config read
  input wire logic        backend_ready_i,   // ready
  input wire logic        backend_stop_i,    // stop request
  input wire logic        backend_abort_i    // abort request
);
  // all checks on the pci clock; reset silences all but the idle check
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_ADDR_CMD: assert property (
    addr_valid_o |-> tgt_addr_wdata_o == $past(pci_ad_i) &&
    tgt_cmd_byte_en_o == $past(pci_cbe_n_i))
    else $error("address strobe carries wrong value");
  AST_VALID_ONCE: assert property (
    addr_valid_o |=> (!addr_valid_o)[*2])
    else $error("address strobe repeated");
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    !reset_n_i |-> !(addr_valid_o || addr_step_o || app_write_o ||
    app_read_o || cfg_write_o || cfg_read_o)) else $error("flag in reset");
  AST_RD_STEP: assert property (
    app_read_o && !pci_trdy_n_o && !pci_irdy_n_i |=> addr_step_o)
    else $error("no step after read transfer");
  AST_STEP_CAUSE: assert property (
    addr_step_o && app_read_o |-> !$past(pci_trdy_n_o) &&
    !$past(pci_irdy_n_i)) else $error("read step without transfer");
  AST_WR_FLAG: assert property (
    $rose(app_write_o) |-> $past(addr_valid_o) && $past(space_hit_i) &&
    $past(app_wr_cmd_hit_i) && !$past(app_rd_cmd_hit_i))
    else $error("write flag without decode");
  AST_RD_FLAG: assert property (
    $rose(app_read_o) |-> $past(addr_valid_o) && $past(space_hit_i) &&
    $past(app_rd_cmd_hit_i)) else $error("read flag without decode");
  AST_WR_HOLD: assert property (
    app_write_o && !pci_frame_n_i |=> app_write_o)
    else $error("write flag dropped");
  AST_RD_HOLD: assert property (
    (app_read_o || cfg_read_o) && !pci_frame_n_i
    |=> $stable({app_read_o, cfg_read_o})) else $error("read flag dropped");
  AST_WAIT: assert property (
    app_read_o && !backend_ready_i && pci_trdy_n_o && !pci_devsel_n_o
    |=> pci_trdy_n_o) else $error("read word without ready");
  AST_STOP: assert property (
    backend_stop_i && !backend_abort_i && !pci_devsel_n_o && !pci_frame_n_i
    |=> !pci_stop_n_o && pci_trdy_n_o) else $error("stop ignored");
  AST_ABORT: assert property (
    backend_abort_i && !pci_devsel_n_o && !pci_frame_n_i
    |=> !pci_stop_n_o && pci_devsel_n_o) else $error("abort ignored");
endmodule

bind pci_target_backend_port pci_target_backend_port_chk
  pci_target_backend_port_chk_i (.*);

/* backend_model.sv */
// backend_model.sv: behavioural user back-end beside the target port
// assumes the port outputs on the same clock and reset
`timescale 1ns/1ps

module backend_model (
  input  wire logic        clk_i,        // pci clock
  input  wire logic        rst_n_i,      // reset, low
  input  wire logic [31:0] addr_wdata_i, // address or word
  input  wire logic [3:0]  cmd_be_i,     // command or enables
  input  wire logic        addr_valid_i, // address strobe
  input  wire logic        addr_step_i,  // one word done
  input  wire logic        app_write_i,  // user write flag
  input  wire logic        cfg_write_i,  // config write flag
  output wire logic        rd_hit_o,     // read decode
  output wire logic        wr_hit_o,     // write decode
  output wire logic        space_hit_o,  // window hit
  output wire logic [31:0] read_word_o,  // user read data
  output wire logic [31:0] cfg_word_o    // config read data
);
  localparam logic [31:0] BASE    = 32'h1000_0000; // 4 KiB window
  localparam logic [15:0] CMD_REG = 16'h0003;      // io, memory on
  logic [31:0] addr_ff;          // own address copy
  logic [31:0] cfg_ff;           // single config word
  logic [5:0]  wr_cnt;           // words taken this access
  logic [31:0] wr_data [0:31];   // words in arrival order
  logic [3:0]  wr_be   [0:31];   // their byte enables

  // io, memory, line and multiple reads
  assign rd_hit_o = cmd_be_i inside {4'h2, 4'h6, 4'hC, 4'hE};
  assign wr_hit_o = cmd_be_i inside {4'h3, 4'h7, 4'hF};
  // window match gated by io or memory enable
  assign space_hit_o = addr_wdata_i[31:12] == BASE[31:12] &&
    (cmd_be_i[3:1] == 3'b001 ? CMD_REG[0] : CMD_REG[1]);
  // data follows the address copy, so order errors show
  assign read_word_o = ~addr_ff;
  assign cfg_word_o  = cfg_ff;

  // address taken once, then four per step
  // a word on every step of a user write, whatever ready says
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_ff <= '0;
      cfg_ff  <= '0;
      wr_cnt  <= '0;
    end else begin
      if (addr_valid_i) begin
        addr_ff <= addr_wdata_i;
        wr_cnt  <= '0;
      end else if (addr_step_i) begin
        addr_ff <= addr_ff + 32'h0000_0004;
      end
      if (app_write_i && addr_step_i) begin
        wr_data[wr_cnt[4:0]] <= addr_wdata_i;
        wr_be[wr_cnt[4:0]]   <= cmd_be_i;
        wr_cnt               <= wr_cnt + 6'h01;
      end
      if (cfg_write_i && addr_step_i) cfg_ff <= addr_wdata_i;
    end
  end
endmodule

/* tb_pci_target_backend_port.sv */
// tb_pci_target_backend_port.sv: self-checking bench of the target port
// assumes design, back-end model and checker compiled before it
`timescale 1ns/1ps

module tb_pci_target_backend_port;
  localparam logic [31:0] BASE = 32'h1000_0000; // back-end window
  logic        clk_i = 1'b0;            // 40 MHz clock
  logic        reset_n_i = 1'b1;        // reset, low; falls at 1 ns
  logic        pci_frame_n_i = 1'b1;    // frame
  logic        pci_irdy_n_i = 1'b1;     // master ready
  logic        pci_idsel_i = 1'b0;      // config select
  logic [31:0] pci_ad_i = '0;           // ad bus
  logic [3:0]  pci_cbe_n_i = 4'hF;      // command / enables
  logic        backend_ready_i = 1'b1;  // ready
  logic        backend_stop_i = 1'b0;   // stop request
  logic        backend_abort_i = 1'b0;  // abort request
  wire  [31:0] pci_ad_o, tgt_addr_wdata_o, backend_read_word_i;
  wire  [31:0] cfg_read_word_i;         // config data from model
  wire  [3:0]  tgt_cmd_byte_en_o;       // command / enables
  wire         pci_ad_oe_o, pci_devsel_n_o, pci_trdy_n_o, pci_stop_n_o;
  wire         pci_tctl_oe_o, addr_valid_o, addr_step_o, app_write_o;
  wire         cfg_write_o, app_read_o, cfg_read_o, space_hit_i;
  wire         app_rd_cmd_hit_i, app_wr_cmd_hit_i; // model decodes
  int          err_count = 0;           // mismatches
  int          samples_checked = 0;     // comparisons
  int          stall = 0;               // 0 ready, 1 periodic, 2 never
  int          cyc = 0;                 // cycle count
  int          done;                    // data phases completed
  logic        stop_seen, abort_seen;   // termination observed
  logic [31:0] rd_seen [0:31];          // read words off the bus

  pci_target_backend_port pci_target_backend_port_i (.*);
  backend_model backend_model_i (
    .clk_i(clk_i), .rst_n_i(reset_n_i), .addr_wdata_i(tgt_addr_wdata_o),
    .cmd_be_i(tgt_cmd_byte_en_o), .addr_valid_i(addr_valid_o),
    .addr_step_i(addr_step_o), .app_write_i(app_write_o),
    .cfg_write_i(cfg_write_o), .rd_hit_o(app_rd_cmd_hit_i),
    .wr_hit_o(app_wr_cmd_hit_i), .space_hit_o(space_hit_i),
    .read_word_o(backend_read_word_i), .cfg_word_o(cfg_read_word_i));

  always #12.5 clk_i = ~clk_i;

  // back-end wait states: periodic stall fills the write buffer
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    #1 backend_ready_i = stall == 0 || (stall == 1 && cyc % 32 >= 25);
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #100us;
    err_count++;
    print_verdict;
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [31:0] wdat(input logic [31:0] a, input int i);
    return a ^ 32'h5A5A_0000 ^ 32'(i);
  endfunction

  // one access as bus master; ends on stop, abort or missing devsel
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr,
                      input int n, input logic sel);
    int w;
    done = 0;
    stop_seen = 1'b0;
    abort_seen = 1'b0;
    pci_frame_n_i = 1'b0;
    pci_ad_i = addr;
    pci_cbe_n_i = cmd;
    pci_idsel_i = sel;
    @(posedge clk_i);
    #1;
    pci_idsel_i = 1'b0;
    pci_irdy_n_i = 1'b0;
    for (w = 0; w < 200 && done < n; w++) begin
      pci_frame_n_i = (done == n - 1);
      pci_ad_i = wdat(addr, done);
      pci_cbe_n_i = 4'(done) ^ 4'h5;
      @(negedge clk_i);
      if (pci_stop_n_o === 1'b0) begin
        abort_seen = pci_devsel_n_o;
        stop_seen = !pci_devsel_n_o;
        break;
      end
      if (w > 6 && pci_devsel_n_o !== 1'b0) break;
      rd_seen[done] = pci_ad_o;
      if (pci_trdy_n_o === 1'b0) done++;
      @(posedge clk_i);
      #1;
    end
    // cut short: frame off first, irdy one clock later
    if (done < n) begin
      @(posedge clk_i);
      #1;
      pci_frame_n_i = 1'b1;
      @(posedge clk_i);
      #1;
    end
    pci_irdy_n_i = 1'b1;
    pci_ad_i = ~pci_ad_i;
    pci_cbe_n_i = 4'hF;
    // released lines change; wait out turnaround and buffer drain
    for (w = 0; w < 400 && (pci_tctl_oe_o || pci_ad_oe_o || app_write_o
         || app_read_o || cfg_write_o || cfg_read_o) !== 1'b0; w++)
      @(posedge clk_i);
    @(posedge clk_i);
    #1;
  endtask

  // every mapped command once, fresh address each round of the loop
  task automatic t_cmds;
    logic [3:0]  wc [0:2] = '{4'h3, 4'h7, 4'hF};
    logic [3:0]  rc [0:3] = '{4'h2, 4'h6, 4'hC, 4'hE};
    logic [31:0] a;
    for (int i = 0; i < 4; i++) begin
      a = BASE + 32'(i * 64);
      if (i < 3) begin
        xfer(wc[i], a, 1, 1'b0);
        check("write word", wdat(a, 0), backend_model_i.wr_data[0]);
      end
      xfer(rc[i], a, 1, 1'b0);
      check("read word", ~a, rd_seen[0]);
    end
  endtask

  // burst longer than the buffer against a stalling back-end
  task automatic t_bursts;
    stall = 1;
    xfer(4'h7, BASE + 32'h0000_0100, 20, 1'b0);
    check("write count", 32'h14, backend_model_i.wr_cnt);
    for (int i = 0; i < 20; i++) begin
      check("burst word", wdat(BASE + 256, i), backend_model_i.wr_data[i]);
      check("burst be", 4'(i) ^ 4'h5, backend_model_i.wr_be[i]);
    end
    xfer(4'h6, BASE + 32'h0000_0200, 4, 1'b0);
    stall = 0;
    check("read phases", 32'h4, done);
    for (int i = 0; i < 4; i++)
      check("burst read", ~(BASE + 512 + 4 * i), rd_seen[i]);
  endtask

  // config write then read back through the config word
  task automatic t_config;
    xfer(4'hB, 32'h0000_0010, 1, 1'b1);
    check("config store", wdat(32'h10, 0), backend_model_i.cfg_ff);
    xfer(4'hA, 32'h0000_0010, 1, 1'b1);
    check("config read", wdat(32'h10, 0), rd_seen[0]);
  endtask

  // miss, disconnect and abort, the last two with no data ready
  task automatic t_refuse;
    xfer(4'h6, 32'h2000_0000, 1, 1'b0);
    check("miss phases", 32'h0, done);
    stall = 2;
    backend_stop_i = 1'b1;
    xfer(4'h6, BASE, 2, 1'b0);
    check("stop seen", 32'h1, stop_seen);
    backend_stop_i = 1'b0;
    backend_abort_i = 1'b1;
    xfer(4'h6, BASE, 2, 1'b0);
    check("abort seen", 32'h1, abort_seen);
    backend_abort_i = 1'b0;
    stall = 0;
  endtask

  // a real falling edge fires the async reset before the first clock
  initial begin
    #1 reset_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    check("reset flags", 32'h0, {addr_valid_o, addr_step_o, app_write_o,
          cfg_write_o, app_read_o, cfg_read_o});
    #1 reset_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    t_cmds;
    t_bursts;
    t_config;
    t_refuse;
    print_verdict;
  end
endmodule
